// ===== design/rss_status.sv
// Ramp and switch status register with switch configuration, APB slave.
// Assumes ramp generator inputs are on ref_clk_in; switch pins are asynchronous.
`timescale 1ns/1ps
`include "rss_defs.svh"
module rss_status #(
  parameter int ADDR_W = 12
) (
  // Clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Ramp generator state
  input wire logic [31:0] actual_position_in,
  input wire logic [31:0] target_position_in,
  input wire logic [31:0] actual_velocity_in,
  input wire logic [31:0] max_velocity_in,
  input wire logic zero_wait_active_in,
  input wire logic second_move_in,
  input wire logic virt_stop_l_in,
  input wire logic virt_stop_r_in,
  input wire logic ramp_hold_in,
  input wire logic move_left_cmd_in,
  input wire logic move_right_cmd_in,
  // Stall detector, qualified by its own source enable
  input wire logic stall_input_active_in,
  // Reference switch pins
  input wire logic ref_l_pin_in,
  input wire logic ref_r_pin_in,
  // Outputs to the motion logic
  output logic int_out,
  output logic stop_l_out,
  output logic stop_r_out,
  output logic stall_halt_out,
  output logic latch_l_out,
  output logic latch_r_out
);

  // Sticky flag update: a set in the same cycle as a clear wins
  function automatic logic sticky(input logic flag, input logic set, input logic clr);
    sticky = set | (flag & ~clr);
  endfunction : sticky

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction : rise

  function automatic logic fall(input logic cur, input logic prev);
    fall = ~cur & prev;
  endfunction : fall

  rss_pkg::rss_phase_t phase;
  rss_pkg::rss_status_t status;
  rss_pkg::rss_config_t switch_config;
  logic [1:0] pin_sync;
  logic sw_l;
  logic sw_r;
  logic sw_l_prev;
  logic sw_r_prev;
  logic pos_match_prev;
  logic stall_prev;
  logic cond_l_prev;
  logic cond_r_prev;
  logic [ADDR_W-1:0] addr_idx;
  logic hit_status;
  logic hit_config;
  logic wr_commit;
  logic [15:0] w1c;
  logic vel_pos;
  logic vel_neg;
  logic cond_l;
  logic cond_r;
  logic moving_l;
  logic moving_r;
  logic latch_l_hit;
  logic latch_r_hit;
  logic stall_set;
  logic stop_l_clr;
  logic stop_r_clr;
  logic [31:0] next_rdata;

  rss_sync #(
    .WIDTH(2)
  ) u_pin_sync (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .async_in({ref_r_pin_in, ref_l_pin_in}),
    .sync_out(pin_sync)
  );

  // Polarity applied after synchronising, so a config write never glitches the filter
  assign sw_l = pin_sync[0] ^ switch_config[`RSS_C_POL_L];
  assign sw_r = pin_sync[1] ^ switch_config[`RSS_C_POL_R];

  // Bus decode; low two address bits ignored
  assign addr_idx = paddr_in >> 2;
  assign hit_status = (addr_idx == ADDR_W'(`RSS_IDX_STATUS));
  assign hit_config = (addr_idx == ADDR_W'(`RSS_IDX_CONFIG));
  assign wr_commit = ce_in & psel_in & penable_in & pready_out & pwrite_in;
  // Only ones written to the status word clear anything
  assign w1c = (wr_commit & hit_status) ? pwdata_in[15:0] : 16'h0000;

  assign vel_pos = ($signed(actual_velocity_in) > $signed(`RSS_ZERO_WORD));
  assign vel_neg = ($signed(actual_velocity_in) < $signed(`RSS_ZERO_WORD));
  assign moving_l = vel_neg | move_left_cmd_in;
  assign moving_r = vel_pos | move_right_cmd_in;

  // Stop sources: physical switch or virtual stop, each gated by its enable
  assign cond_l = (sw_l & switch_config[`RSS_C_STOP_L_EN])
                | (virt_stop_l_in & switch_config[`RSS_C_VSTOP_L_EN]);
  assign cond_r = (sw_r & switch_config[`RSS_C_STOP_R_EN])
                | (virt_stop_r_in & switch_config[`RSS_C_VSTOP_R_EN]);

  // Hold, an opposite move, or a disabled stop function all drop the flag
  always_comb begin
    stop_l_clr = ramp_hold_in | move_right_cmd_in;
    stop_r_clr = ramp_hold_in | move_left_cmd_in;
    if (!switch_config[`RSS_C_STOP_L_EN] && !switch_config[`RSS_C_VSTOP_L_EN]) begin
      stop_l_clr = 1'b1;
    end
    if (!switch_config[`RSS_C_STOP_R_EN] && !switch_config[`RSS_C_VSTOP_R_EN]) begin
      stop_r_clr = 1'b1;
    end
    if (!cond_l) begin
      // Soft stop keeps the flag until motion toward the switch has ended
      if (!switch_config[`RSS_C_SOFT_STOP] || !vel_neg) begin
        stop_l_clr = 1'b1;
      end
    end
    if (!cond_r) begin
      if (!switch_config[`RSS_C_SOFT_STOP] || !vel_pos) begin
        stop_r_clr = 1'b1;
      end
    end
  end

  // Latch edges on the polarity-corrected switch levels
  assign latch_l_hit = (rise(sw_l, sw_l_prev) & switch_config[`RSS_C_LATCH_L_ACT])
                     | (fall(sw_l, sw_l_prev) & switch_config[`RSS_C_LATCH_L_INACT]);
  assign latch_r_hit = (rise(sw_r, sw_r_prev) & switch_config[`RSS_C_LATCH_R_ACT])
                     | (fall(sw_r, sw_r_prev) & switch_config[`RSS_C_LATCH_R_INACT]);

  assign stall_set = stall_input_active_in & switch_config[`RSS_C_STALL_HALT_EN];

  // Edge history
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sw_l_prev <= 1'b0;
      sw_r_prev <= 1'b0;
      pos_match_prev <= 1'b0;
      stall_prev <= 1'b0;
      cond_l_prev <= 1'b0;
      cond_r_prev <= 1'b0;
    end else if (ce_in) begin
      sw_l_prev <= sw_l;
      sw_r_prev <= sw_r;
      pos_match_prev <= status[`RSS_B_POS];
      stall_prev <= stall_set;
      cond_l_prev <= cond_l & moving_l;
      cond_r_prev <= cond_r & moving_r;
    end
  end

  // Live status bits and the sticky second-move flag, one cycle behind their sources
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status[15:8] <= 8'(`RSS_STATUS_RST >> 8);
      status[`RSS_B_SW_R] <= 1'b0;
      status[`RSS_B_SW_L] <= 1'b0;
    end else if (ce_in) begin
      status[`RSS_B_VSTOP_R] <= virt_stop_r_in;
      status[`RSS_B_VSTOP_L] <= virt_stop_l_in;
      status[`RSS_B_STALL] <= stall_input_active_in;
      status[`RSS_B_SECOND] <= sticky(status[`RSS_B_SECOND], second_move_in, w1c[`RSS_B_SECOND]);
      status[`RSS_B_ZWAIT] <= zero_wait_active_in;
      status[`RSS_B_VZERO] <= (actual_velocity_in == `RSS_ZERO_WORD);
      status[`RSS_B_POS] <= (actual_position_in == target_position_in);
      status[`RSS_B_VEL] <= (actual_velocity_in == max_velocity_in);
      status[`RSS_B_SW_R] <= sw_r;
      status[`RSS_B_SW_L] <= sw_l;
    end
  end

  // Event flags
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status[`RSS_B_EV_POS] <= 1'b0;
      status[`RSS_B_EV_STALL] <= 1'b0;
      status[`RSS_B_LATCH_R] <= 1'b0;
      status[`RSS_B_LATCH_L] <= 1'b0;
    end else if (ce_in) begin
      status[`RSS_B_EV_POS] <= sticky(status[`RSS_B_EV_POS],
                                      rise(status[`RSS_B_POS], pos_match_prev), w1c[`RSS_B_EV_POS]);
      status[`RSS_B_EV_STALL] <= sticky(status[`RSS_B_EV_STALL],
                                        rise(stall_set, stall_prev), w1c[`RSS_B_EV_STALL]);
      status[`RSS_B_LATCH_R] <= sticky(status[`RSS_B_LATCH_R], latch_r_hit, w1c[`RSS_B_LATCH_R]);
      status[`RSS_B_LATCH_L] <= sticky(status[`RSS_B_LATCH_L], latch_l_hit, w1c[`RSS_B_LATCH_L]);
    end
  end

  // Stop flags: set on the onset of a stop while heading into it; ramp actions win
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status[`RSS_B_EV_STOP_R] <= 1'b0;
      status[`RSS_B_EV_STOP_L] <= 1'b0;
    end else if (ce_in) begin
      if (stop_r_clr) begin
        status[`RSS_B_EV_STOP_R] <= 1'b0;
      end else if (rise(cond_r & moving_r, cond_r_prev)) begin
        status[`RSS_B_EV_STOP_R] <= 1'b1;
      end
      if (stop_l_clr) begin
        status[`RSS_B_EV_STOP_L] <= 1'b0;
      end else if (rise(cond_l & moving_l, cond_l_prev)) begin
        status[`RSS_B_EV_STOP_L] <= 1'b1;
      end
    end
  end

  // Switch configuration register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      switch_config <= `RSS_CONFIG_RST;
    end else if (wr_commit && hit_config) begin
      switch_config <= pwdata_in[11:0];
    end
  end

  // Outputs to the motion logic
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      int_out <= 1'b0;
      stop_l_out <= 1'b0;
      stop_r_out <= 1'b0;
      stall_halt_out <= 1'b0;
      latch_l_out <= 1'b0;
      latch_r_out <= 1'b0;
    end else if (ce_in) begin
      int_out <= status[`RSS_B_EV_POS] | status[`RSS_B_EV_STALL]
               | status[`RSS_B_EV_STOP_R] | status[`RSS_B_EV_STOP_L];
      stop_l_out <= status[`RSS_B_EV_STOP_L];
      stop_r_out <= status[`RSS_B_EV_STOP_R];
      // Halt held only while the event is pending and halting is enabled
      stall_halt_out <= status[`RSS_B_EV_STALL] & switch_config[`RSS_C_STALL_HALT_EN];
      latch_l_out <= latch_l_hit;
      latch_r_out <= latch_r_hit;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = `RSS_ZERO_WORD;
    if (hit_status) begin
      next_rdata = {16'h0000, status};
    end else if (hit_config) begin
      next_rdata = {20'h0_0000, switch_config};
    end
  end

  // APB: one wait state, then the answer for one cycle
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase <= rss_pkg::RSS_IDLE;
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= `RSS_ZERO_WORD;
    end else if (ce_in) begin
      case (phase)
        rss_pkg::RSS_IDLE: begin
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
          if (psel_in && !penable_in) begin
            phase <= rss_pkg::RSS_WAIT;
          end
        end
        rss_pkg::RSS_WAIT: begin
          if (psel_in && penable_in) begin
            phase <= rss_pkg::RSS_DONE;
            pready_out <= 1'b1;
            pslverr_out <= ~(hit_status | hit_config);
            prdata_out <= pwrite_in ? `RSS_ZERO_WORD : next_rdata;
          end else begin
            phase <= rss_pkg::RSS_IDLE;
          end
        end
        rss_pkg::RSS_DONE: begin
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
          phase <= rss_pkg::RSS_IDLE;
        end
        default: begin
          phase <= rss_pkg::RSS_IDLE;
          pready_out <= 1'b0;
          pslverr_out <= 1'b0;
        end
      endcase
    end
  end

endmodule : rss_status

// ===== design/rss_defs.svh
// Constants for the ramp and switch status register block.
// Assumes a 32-bit APB slave; included by every design file that needs it.
//
// Function
// - Bit 15 shows the right virtual stop condition, read-only.
// - Bit 14 shows the left virtual stop condition, read-only.
// - Bit 13 shows the enabled stall input, read-only.
// - Bit 12 sets when the ramp reverses for a second move; write one clears.
// - Bit 11 shows the post-stop standstill wait interval.
// - Bit 10 shows ramp velocity equal to zero.
// - Bit 9 shows actual position equal to target position.
// - Bit 8 shows actual velocity equal to maximum velocity.
// - Bit 7 sets on position match rising; write one clears; drives interrupt.
// - Bit 6 sets on stall halt event; write one clears; drives interrupt.
// - Clearing the stall halt event releases the stall halt.
// - Bit 5 shows right stop from switch or virtual stop; drives interrupt.
// - Bit 4 shows left stop from switch or virtual stop; drives interrupt.
// - Hold mode or an opposite move command removes a stop condition.
// - In soft stop the condition stays until motion toward the switch ends.
// - Disabling the switch or stop function clears the flag, motor continues.
// - Bit 3 sets on an enabled right switch latch edge; write one clears.
// - Bit 2 sets on an enabled left switch latch edge; write one clears.
// - Bits 1 and 0 show right and left switch inputs at active level.
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// Register indices; byte address is four times the index
`define RSS_IDX_STATUS 10'h035
`define RSS_IDX_CONFIG 10'h034

// Status bit positions
`define RSS_B_VSTOP_R 15
`define RSS_B_VSTOP_L 14
`define RSS_B_STALL 13
`define RSS_B_SECOND 12
`define RSS_B_ZWAIT 11
`define RSS_B_VZERO 10
`define RSS_B_POS 9
`define RSS_B_VEL 8
`define RSS_B_EV_POS 7
`define RSS_B_EV_STALL 6
`define RSS_B_EV_STOP_R 5
`define RSS_B_EV_STOP_L 4
`define RSS_B_LATCH_R 3
`define RSS_B_LATCH_L 2
`define RSS_B_SW_R 1
`define RSS_B_SW_L 0

// Switch configuration bit positions
`define RSS_C_STOP_L_EN 0
`define RSS_C_STOP_R_EN 1
`define RSS_C_POL_L 2
`define RSS_C_POL_R 3
`define RSS_C_LATCH_L_ACT 4
`define RSS_C_LATCH_L_INACT 5
`define RSS_C_LATCH_R_ACT 6
`define RSS_C_LATCH_R_INACT 7
`define RSS_C_STALL_HALT_EN 8
`define RSS_C_SOFT_STOP 9
`define RSS_C_VSTOP_L_EN 10
`define RSS_C_VSTOP_R_EN 11
`define RSS_CONFIG_MASK 32'h0000_0FFF

// Reset values
`define RSS_STATUS_RST 16'hC000
`define RSS_CONFIG_RST 12'h000
`define RSS_ZERO_WORD 32'h0000_0000

`endif

// ===== design/rss_pkg.sv
// Types shared by the ramp and switch status block.
// Assumes nothing beyond a 32-bit register bus.
package rss_pkg;
  typedef logic [31:0] rss_word_t;
  typedef logic [15:0] rss_status_t;
  typedef logic [11:0] rss_config_t;
  // Bus phase of the slave, Gray along idle, wait, answer
  typedef enum logic [1:0] {
    RSS_IDLE = 2'b00,
    RSS_WAIT = 2'b01,
    RSS_DONE = 2'b11
  } rss_phase_t;
endpackage : rss_pkg

// ===== design/rss_sync.sv
// Three-stage synchroniser for asynchronous pin levels.
// Assumes pins are quasi-static relative to the clock.
`timescale 1ns/1ps
module rss_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else if (ce_in) begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change only once two late stages agree, filtering one-cycle glitches
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_out <= '0;
    end else if (ce_in) begin
      if (stage2 == stage3) begin
        sync_out <= stage3;
      end
    end
  end
endmodule : rss_sync

// ===== bench/rss_status_monitor.sv
// Concurrent checks on the status block ports, bound to rss_status.
// Assumes ce_in high and a master that holds each request until pready.
`timescale 1ns/1ps
module rss_status_monitor #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // Ramp commands
  input wire logic ramp_hold_in,
  input wire logic move_left_cmd_in,
  input wire logic move_right_cmd_in,
  // Motion outputs
  input wire logic int_out,
  input wire logic stop_l_out,
  input wire logic stop_r_out,
  input wire logic stall_halt_out,
  input wire logic latch_l_out,
  input wire logic latch_r_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  logic st_hit;
  logic mapped;
  assign st_hit = 32'(paddr_in) == 32'h0000_00D4;
  assign mapped = st_hit || (32'(paddr_in) == 32'h0000_00D0);
  sequence s_setup;
    psel_in && !penable_in && ce_in;
  endsequence
  sequence s_access;
    psel_in && penable_in && ce_in;
  endsequence
  chk_answer_late: assert property (s_setup ##1 s_access |-> !pready_out ##1 pready_out)
    else $error("answer not in second access cycle");
  chk_ready_pulse: assert property (pready_out |=> !pready_out) else $error("pready longer than one cycle");
  chk_err_refused: assert property (pready_out && !mapped |-> pslverr_out && prdata_out == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready_out && mapped |-> !pslverr_out) else $error("mapped access refused");
  chk_int_stops: assert property (stop_l_out || stop_r_out |-> int_out)
    else $error("stop flag without interrupt");
  chk_hold_clear: assert property (ramp_hold_in ##1 ramp_hold_in |=> !stop_l_out && !stop_r_out)
    else $error("hold left a stop active");
  chk_opp_left: assert property (move_right_cmd_in [*2] |=> !stop_l_out)
    else $error("right move kept left stop");
  chk_opp_right: assert property (move_left_cmd_in [*2] |=> !stop_r_out)
    else $error("left move kept right stop");
  chk_stall_release: assert property (pready_out && pwrite_in && st_hit && pwdata_in[6] |-> ##[1:2] !stall_halt_out)
    else $error("stall halt not released");
  chk_latch_pulse: assert property (latch_l_out || latch_r_out |=> !latch_l_out && !latch_r_out)
    else $error("latch pulse too long");
endmodule : rss_status_monitor

bind rss_status rss_status_monitor #(.ADDR_W(ADDR_W)) rss_status_monitor_inst (.ref_clk_in(ref_clk_in),
  .rstn_in(rstn_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
  .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .ramp_hold_in(ramp_hold_in), .move_left_cmd_in(move_left_cmd_in),
  .move_right_cmd_in(move_right_cmd_in), .int_out(int_out), .stop_l_out(stop_l_out), .stop_r_out(stop_r_out),
  .stall_halt_out(stall_halt_out), .latch_l_out(latch_l_out), .latch_r_out(latch_r_out));

// ===== bench/rss_status_bench.sv
// Self-checking bench for the ramp and switch status register.
// Assumes the design and checker are compiled first; drives every port itself.
`timescale 1ns/1ps
module rss_status_bench;
  localparam logic [11:0] A_ST = 12'h0D4;
  localparam logic [11:0] A_CF = 12'h0D0;
  logic ref_clk_in, rstn_in, ce_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, act_pos, tgt_pos, act_vel, max_vel;
  logic zwait, second, vs_l, vs_r, hold, mv_l, mv_r, stall, pin_l, pin_r;
  logic int_out, stop_l_out, stop_r_out, stall_halt_out, latch_l_out, latch_r_out;
  int n_fail = 0;
  int total_checks = 0;
  rss_status rss_status_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .actual_position_in(act_pos),
    .target_position_in(tgt_pos), .actual_velocity_in(act_vel), .max_velocity_in(max_vel),
    .zero_wait_active_in(zwait), .second_move_in(second), .virt_stop_l_in(vs_l), .virt_stop_r_in(vs_r),
    .ramp_hold_in(hold), .move_left_cmd_in(mv_l), .move_right_cmd_in(mv_r), .stall_input_active_in(stall),
    .ref_l_pin_in(pin_l), .ref_r_pin_in(pin_r), .int_out(int_out), .stop_l_out(stop_l_out),
    .stop_r_out(stop_r_out), .stall_halt_out(stall_halt_out), .latch_l_out(latch_l_out),
    .latch_r_out(latch_r_out));
  initial begin
    ref_clk_in = 1'b0;
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic chkf(input string name, input logic exp, input logic got);
    chk(name, {31'h0, exp}, {31'h0, got});
  endtask : chkf
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    // Request stands until pready is seen high at a rising edge
    do @(posedge ref_clk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    chkf("slverr", (a != A_ST) && (a != A_CF), pslverr_out);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    apb(1'b0, a, 32'h0000_0000, r);
    chk("read data", exp, r);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr
  // Switch pins pass a synchroniser, so allow several edges
  task automatic settle;
    repeat (8) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
  endtask : settle
  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic t_live;
    rd(A_ST, 32'h0000_C000);
    rd(A_CF, 32'h0000_0000);
    @(posedge ref_clk_in);
    vs_l <= 1'b0;
    zwait <= 1'b1;
    act_vel <= 32'h0000_0009;
    settle;
    rd(A_ST, 32'h0000_8900);
    @(posedge ref_clk_in);
    vs_r <= 1'b0;
    zwait <= 1'b0;
    act_vel <= 32'h0000_0000;
    settle;
    rd(A_ST, 32'h0000_0400);
    @(posedge ref_clk_in);
    act_vel <= 32'h0000_0005;
  endtask : t_live
  task automatic t_pos;
    // Match arrives while the clock enable is low: nothing may move
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    tgt_pos <= 32'h0000_0000;
    settle;
    chkf("frozen int", 1'b0, int_out);
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    settle;
    chkf("int", 1'b1, int_out);
    rd(A_ST, 32'h0000_0280);
    wr(A_ST, 32'hFFFF_FF7F);
    rd(A_ST, 32'h0000_0280);
    wr(A_ST, 32'h0000_0080);
    settle;
    chkf("int", 1'b0, int_out);
    rd(A_ST, 32'h0000_0200);
    @(posedge ref_clk_in);
    tgt_pos <= 32'h0000_0001;
  endtask : t_pos
  task automatic t_stall;
    wr(A_CF, 32'h0000_0100);
    @(posedge ref_clk_in);
    stall <= 1'b1;
    settle;
    chkf("stall halt", 1'b1, stall_halt_out);
    rd(A_ST, 32'h0000_2040);
    wr(A_ST, 32'h0000_0040);
    settle;
    chkf("stall halt", 1'b0, stall_halt_out);
    rd(A_ST, 32'h0000_2000);
    @(posedge ref_clk_in);
    stall <= 1'b0;
    wr(A_CF, 32'h0000_0000);
  endtask : t_stall
  task automatic t_stop;
    wr(A_CF, 32'h0000_0002);
    @(posedge ref_clk_in);
    pin_r <= 1'b1;
    settle;
    chkf("stop right", 1'b1, stop_r_out);
    rd(A_ST, 32'h0000_0022);
    @(posedge ref_clk_in);
    hold <= 1'b1;
    settle;
    chkf("int", 1'b0, int_out);
    rd(A_ST, 32'h0000_0002);
    @(posedge ref_clk_in);
    hold <= 1'b0;
    pin_r <= 1'b0;
    settle;
    @(posedge ref_clk_in);
    pin_r <= 1'b1;
    settle;
    rd(A_ST, 32'h0000_0022);
    wr(A_CF, 32'h0000_0000);
    settle;
    chkf("stop right", 1'b0, stop_r_out);
    rd(A_ST, 32'h0000_0002);
    @(posedge ref_clk_in);
    pin_r <= 1'b0;
  endtask : t_stop
  task automatic t_left;
    wr(A_CF, 32'h0000_0400);
    @(posedge ref_clk_in);
    act_vel <= 32'hFFFF_FFFB;
    vs_l <= 1'b1;
    settle;
    chkf("stop left", 1'b1, stop_l_out);
    rd(A_ST, 32'h0000_4010);
    @(posedge ref_clk_in);
    mv_r <= 1'b1;
    settle;
    rd(A_ST, 32'h0000_4000);
    @(posedge ref_clk_in);
    mv_r <= 1'b0;
    vs_l <= 1'b0;
    act_vel <= 32'h0000_0005;
    wr(A_CF, 32'h0000_0000);
  endtask : t_left
  task automatic t_soft;
    wr(A_CF, 32'h0000_0202);
    @(posedge ref_clk_in);
    pin_r <= 1'b1;
    settle;
    @(posedge ref_clk_in);
    pin_r <= 1'b0;
    settle;
    rd(A_ST, 32'h0000_0020);
    @(posedge ref_clk_in);
    act_vel <= 32'h0000_0000;
    settle;
    rd(A_ST, 32'h0000_0400);
    @(posedge ref_clk_in);
    act_vel <= 32'h0000_0005;
    wr(A_CF, 32'h0000_0000);
  endtask : t_soft
  task automatic t_latch;
    wr(A_CF, 32'h0000_0050);
    @(posedge ref_clk_in);
    pin_l <= 1'b1;
    pin_r <= 1'b1;
    // Synchroniser plus edge register: pulse stands one cycle
    repeat (5) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chkf("latch left", 1'b1, latch_l_out);
    chkf("latch right", 1'b1, latch_r_out);
    settle;
    chkf("latch left", 1'b0, latch_l_out);
    rd(A_ST, 32'h0000_000F);
    wr(A_ST, 32'h0000_0008);
    rd(A_ST, 32'h0000_0007);
    wr(A_ST, 32'h0000_0004);
    rd(A_ST, 32'h0000_0003);
    @(posedge ref_clk_in);
    pin_l <= 1'b0;
    pin_r <= 1'b0;
    wr(A_CF, 32'h0000_0000);
    @(posedge ref_clk_in);
    second <= 1'b1;
    @(posedge ref_clk_in);
    second <= 1'b0;
    settle;
    rd(A_ST, 32'h0000_1000);
    wr(A_ST, 32'h0000_1000);
    rd(A_ST, 32'h0000_0000);
    wr(12'h0D8, 32'hFFFF_FFFF);
    rd(12'h0D8, 32'h0000_0000);
  endtask : t_latch
  initial begin
    {rstn_in, psel_in, penable_in, pwrite_in, zwait, second, hold, mv_l, mv_r, stall, pin_l, pin_r} = '0;
    {ce_in, vs_l, vs_r} = 3'b111;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    act_pos = 32'h0000_0000;
    tgt_pos = 32'h0000_0001;
    act_vel = 32'h0000_0005;
    max_vel = 32'h0000_0009;
    repeat (8) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    t_live;
    t_pos;
    t_stall;
    t_stop;
    t_left;
    t_soft;
    t_latch;
    stop_test;
  end
  // Whole run is a few hundred cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    n_fail++;
    stop_test;
  end
endmodule : rss_status_bench
